/* File: pkg/bstreg_defines.vh */
`ifndef BSTREG_DEFINES_VH
`define BSTREG_DEFINES_VH
`define BSTREG_I2C_VOUT_ADDR 8'h88
`define BSTREG_I2C_CTRL_ADDR 8'h89
`define BSTREG_UC_VOUT_ADDR 16'hA088
`define BSTREG_UC_CTRL_ADDR 16'hA089
`define BSTREG_VOUT_RST 8'h13
`define BSTREG_CTRL_RST 8'h0E
`define BSTREG_EN_BIT 7
`define BSTREG_CODE_MSB 4
`define BSTREG_CLK_BIT 1
`define BSTREG_ILIM_MSB 3
`define BSTREG_ILIM_LSB 2
`define BSTREG_PG_BIT 5
`define BSTREG_CTRL_WMASK 8'hDF
`define BSTREG_RD_NONE 8'h00
`define BSTREG_SS_TIME_US 500
`define BSTREG_CLK_MHZ 20
`define BSTREG_SS_WIDTH 14
`define BSTREG_BASE_MV 4050
`define BSTREG_STEP_MV 50
`endif

/* File: rtl/bstreg_regs.v */
`timescale 1ns/1ps
`include "bstreg_defines.vh"
module bstreg_regs (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire i2c_wr,
  input wire [7:0] i2c_addr,
  input wire [7:0] i2c_wdata,
  output reg [7:0] i2c_rdata_ff,
  input wire uc_wr,
  input wire [15:0] uc_addr,
  input wire [7:0] uc_wdata,
  output reg [7:0] uc_rdata_ff,
  input wire global_enable,
  input wire power_good_in,
  output reg regulator_on_ff,
  output reg [4:0] output_voltage_code_ff,
  output reg [12:0] target_mv_ff,
  output reg clock_1mhz_sel_ff,
  output reg [1:0] peak_current_limit_select_ff,
  output reg soft_start_ff
);
  localparam SSW = `BSTREG_SS_WIDTH;
  localparam integer SS_CYCLES_INT = `BSTREG_SS_TIME_US * `BSTREG_CLK_MHZ;
  localparam [SSW-1:0] SS_CYCLES = SS_CYCLES_INT[SSW-1:0];
  localparam [SSW-1:0] SS_ZERO = {SSW{1'b0}};
  localparam [SSW-1:0] SS_ONE = {{(SSW-1){1'b0}}, 1'b1};
  localparam [7:0] VOUT_RST = `BSTREG_VOUT_RST;
  localparam [7:0] CTRL_RST = `BSTREG_CTRL_RST;
  localparam [7:0] RD_NONE = `BSTREG_RD_NONE;
  localparam [7:0] CTRL_WMASK = `BSTREG_CTRL_WMASK;
  localparam SEL_VOUT = 0;
  localparam SEL_CTRL = 1;

  reg [7:0] vout_reg_ff;
  reg [7:0] ctrl_reg_ff;
  reg ge_s1_ff;
  reg ge_s2_ff;
  reg pg_s1_ff;
  reg pg_s2_ff;
  reg [SSW-1:0] ss_cnt_ff;
  reg [7:0] nxt_vout;
  reg [7:0] nxt_ctrl;
  reg [SSW-1:0] nxt_ss_cnt;
  reg nxt_soft_start;
  wire [1:0] i2c_sel;
  wire [1:0] uc_sel;
  wire i2c_vout_hit;
  wire i2c_ctrl_hit;
  wire uc_vout_hit;
  wire uc_ctrl_hit;
  wire [7:0] ctrl_view;
  wire run;
  wire turn_on;

  function [12:0] code_to_mv;
    input [4:0] code;
    reg [31:0] mv_wide;
    begin
      mv_wide = `BSTREG_BASE_MV + code * `BSTREG_STEP_MV;
      code_to_mv = mv_wide[12:0];
    end
  endfunction

  // One-hot select, shared by the write strobes and the read mux
  function [1:0] i2c_decode;
    input [7:0] addr;
    begin
      i2c_decode = 2'h0;
      if (addr == `BSTREG_I2C_VOUT_ADDR)
      begin
        i2c_decode[SEL_VOUT] = 1'b1;
      end
      if (addr == `BSTREG_I2C_CTRL_ADDR)
      begin
        i2c_decode[SEL_CTRL] = 1'b1;
      end
    end
  endfunction

  function [1:0] uc_decode;
    input [15:0] addr;
    begin
      uc_decode = 2'h0;
      if (addr == `BSTREG_UC_VOUT_ADDR)
      begin
        uc_decode[SEL_VOUT] = 1'b1;
      end
      if (addr == `BSTREG_UC_CTRL_ADDR)
      begin
        uc_decode[SEL_CTRL] = 1'b1;
      end
    end
  endfunction

  function [7:0] read_mux;
    input [1:0] sel;
    input [7:0] vout;
    input [7:0] ctrl;
    begin
      read_mux = RD_NONE;
      if (sel[SEL_VOUT])
      begin
        read_mux = vout;
      end
      if (sel[SEL_CTRL])
      begin
        read_mux = ctrl;
      end
    end
  endfunction

  function [7:0] with_pg;
    input [7:0] ctrl;
    input pg;
    begin
      with_pg = ctrl;
      with_pg[`BSTREG_PG_BIT] = pg;
    end
  endfunction

  assign i2c_sel = i2c_decode(i2c_addr);
  assign uc_sel = uc_decode(uc_addr);
  assign i2c_vout_hit = i2c_wr && i2c_sel[SEL_VOUT];
  assign i2c_ctrl_hit = i2c_wr && i2c_sel[SEL_CTRL];
  assign uc_vout_hit = uc_wr && uc_sel[SEL_VOUT];
  assign uc_ctrl_hit = uc_wr && uc_sel[SEL_CTRL];
  // Power good bit shows live status, never the stored bit
  assign ctrl_view = with_pg(ctrl_reg_ff, pg_s2_ff);
  assign run = ge_s2_ff && vout_reg_ff[`BSTREG_EN_BIT];
  assign turn_on = run && !regulator_on_ff;

  // Same-cycle writes from both masters: local controller wins
  always @*
  begin
    nxt_vout = vout_reg_ff;
    nxt_ctrl = ctrl_reg_ff;
    if (i2c_vout_hit)
    begin
      nxt_vout = i2c_wdata;
    end
    if (uc_vout_hit)
    begin
      nxt_vout = uc_wdata;
    end
    if (i2c_ctrl_hit)
    begin
      nxt_ctrl = i2c_wdata & CTRL_WMASK;
    end
    if (uc_ctrl_hit)
    begin
      nxt_ctrl = uc_wdata & CTRL_WMASK;
    end
  end

  // Restart soft start whenever the regulator turns on
  always @*
  begin
    nxt_ss_cnt = ss_cnt_ff;
    nxt_soft_start = soft_start_ff;
    if (turn_on)
    begin
      nxt_ss_cnt = SS_CYCLES;
      nxt_soft_start = 1'b1;
    end
    else if (!run)
    begin
      nxt_ss_cnt = SS_ZERO;
      nxt_soft_start = 1'b0;
    end
    else if (ss_cnt_ff != SS_ZERO)
    begin
      nxt_ss_cnt = ss_cnt_ff - SS_ONE;
      nxt_soft_start = (ss_cnt_ff != SS_ONE);
    end
  end

  // Enable and status levels come from other domains
  always @(posedge clk)
  begin
    if (rst)
    begin
      ge_s1_ff <= 1'b0;
      ge_s2_ff <= 1'b0;
    end
    else if (ce)
    begin
      ge_s1_ff <= global_enable;
      ge_s2_ff <= ge_s1_ff;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      pg_s1_ff <= 1'b0;
      pg_s2_ff <= 1'b0;
    end
    else if (ce)
    begin
      pg_s1_ff <= power_good_in;
      pg_s2_ff <= pg_s1_ff;
    end
  end

  // Only power-on reset reloads defaults; enables never touch them
  always @(posedge clk)
  begin
    if (rst)
    begin
      vout_reg_ff <= VOUT_RST;
    end
    else if (ce)
    begin
      vout_reg_ff <= nxt_vout;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg_ff <= CTRL_RST;
    end
    else if (ce)
    begin
      ctrl_reg_ff <= nxt_ctrl;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      output_voltage_code_ff <= VOUT_RST[`BSTREG_CODE_MSB:0];
      target_mv_ff <= code_to_mv(VOUT_RST[`BSTREG_CODE_MSB:0]);
    end
    else if (ce)
    begin
      output_voltage_code_ff <= vout_reg_ff[`BSTREG_CODE_MSB:0];
      target_mv_ff <= code_to_mv(vout_reg_ff[`BSTREG_CODE_MSB:0]);
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      clock_1mhz_sel_ff <= CTRL_RST[`BSTREG_CLK_BIT];
      peak_current_limit_select_ff <= CTRL_RST[`BSTREG_ILIM_MSB:`BSTREG_ILIM_LSB];
    end
    else if (ce)
    begin
      clock_1mhz_sel_ff <= ctrl_reg_ff[`BSTREG_CLK_BIT];
      peak_current_limit_select_ff <= ctrl_reg_ff[`BSTREG_ILIM_MSB:`BSTREG_ILIM_LSB];
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      regulator_on_ff <= 1'b0;
    end
    else if (ce)
    begin
      regulator_on_ff <= run;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      ss_cnt_ff <= SS_ZERO;
      soft_start_ff <= 1'b0;
    end
    else if (ce)
    begin
      ss_cnt_ff <= nxt_ss_cnt;
      soft_start_ff <= nxt_soft_start;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      i2c_rdata_ff <= RD_NONE;
    end
    else if (ce)
    begin
      i2c_rdata_ff <= read_mux(i2c_sel, vout_reg_ff, ctrl_view);
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      uc_rdata_ff <= RD_NONE;
    end
    else if (ce)
    begin
      uc_rdata_ff <= read_mux(uc_sel, vout_reg_ff, ctrl_view);
    end
  end
endmodule

/* File: verif/bstreg_asserts.sv */
`timescale 1ns/1ps
module bstreg_asserts (
  input wire clk, rst, ce, i2c_wr, uc_wr, global_enable,
  input wire [7:0] i2c_addr, i2c_wdata, i2c_rdata_ff, uc_wdata,
  input wire [15:0] uc_addr,
  input wire regulator_on_ff, clock_1mhz_sel_ff, soft_start_ff,
  input wire [4:0] output_voltage_code_ff,
  input wire [12:0] target_mv_ff,
  input wire [1:0] peak_current_limit_select_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire quiet = !i2c_wr && !uc_wr;
  a_target_mv: assert property ($stable(output_voltage_code_ff) |->
    target_mv_ff == 13'hFD2 + 13'h32 * output_voltage_code_ff) else $error("target mv");
  a_reset_vals: assert property ($fell(rst) |-> output_voltage_code_ff == 5'h13
    && clock_1mhz_sel_ff && peak_current_limit_select_ff == 2'h3 && !regulator_on_ff)
    else $error("reset values");
  a_vout_rdback: assert property (i2c_wr && ce && i2c_addr == 8'h88 && !uc_wr
    ##1 (quiet && i2c_addr == 8'h88) [*2] |-> i2c_rdata_ff == $past(i2c_wdata, 2))
    else $error("vout readback");
  a_ctrl_write: assert property (uc_wr && ce && uc_addr == 16'hA089 && !i2c_wr
    ##1 quiet [*2] |-> {peak_current_limit_select_ff, clock_1mhz_sel_ff}
    == $past(uc_wdata[3:1], 2)) else $error("ctrl fields");
  a_unmapped_zero: assert property (i2c_addr[7:1] != 7'h44 ##1 $stable(i2c_addr)
    |-> i2c_rdata_ff == 8'h00) else $error("unmapped read");
  a_global_off: assert property (!global_enable [*4] |-> !regulator_on_ff)
    else $error("on without global");
  a_ss_start: assert property ($rose(regulator_on_ff) |-> soft_start_ff)
    else $error("soft start begin");
  a_ss_hold: assert property ($rose(soft_start_ff) |=> soft_start_ff [*8])
    else $error("soft start short");
endmodule

/* File: verif/bstreg_analog.sv */
`timescale 1ns/1ps
module bstreg_analog (
  input wire clk,
  input wire on,
  output wire pg
);
  // Output takes a few cycles to rise, so power good never follows enable at once
  reg [2:0] up_ff = 3'h0;
  always @(posedge clk)
    up_ff <= on ? up_ff + {2'h0, ~&up_ff} : 3'h0;
  assign pg = &up_ff;
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
`define CHK(n, a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  reg clk = 0, rst = 1, ge = 0, wr_i = 0, wr_u = 0, ce = 1;
  reg [7:0] ai = 8'h00, di = 8'h00;
  reg [15:0] au = 16'h0000;
  wire [7:0] ri, ru;
  wire on, ss, cs, pg;
  wire [4:0] code;
  wire [12:0] mv;
  wire [1:0] lim;
  int n_mismatch = 0, n_compared = 0, i;
  always #25 clk = ~clk;
  bstreg_regs uut (.clk(clk), .rst(rst), .ce(ce), .i2c_wr(wr_i), .i2c_addr(ai),
    .i2c_wdata(di), .i2c_rdata_ff(ri), .uc_wr(wr_u), .uc_addr(au), .uc_wdata(di),
    .uc_rdata_ff(ru), .global_enable(ge), .power_good_in(pg), .regulator_on_ff(on),
    .output_voltage_code_ff(code), .target_mv_ff(mv), .clock_1mhz_sel_ff(cs),
    .peak_current_limit_select_ff(lim), .soft_start_ff(ss));
  bstreg_analog ana (.clk(clk), .on(on), .pg(pg));
  task wr(input bit u, input [7:0] a, input [7:0] d);
    @(negedge clk);
    {wr_u, wr_i, ai, au, di} = {u, !u, a, 8'hA0, a, d};
    @(negedge clk);
    {wr_u, wr_i} = 2'b00;
  endtask
  // Both ports read at once so each address map is checked on every read
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    {ai, au} = {a, 8'hA0, a};
    repeat (3) @(negedge clk);
    `CHK("i2c read", ri, e)
    `CHK("uc read", ru, e)
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 0;
    rd(8'h88, 8'h13);
    rd(8'h89, 8'h0E);
    rd(8'h8A, 8'h00);
    $display("test defaults done");
    for (i = 0; i < 4; i++)
    begin
      wr(1, 8'h89, {4'hF, i[1:0], 2'b01});
      rd(8'h89, {4'hD, i[1:0], 2'b01});
      `CHK("ilim", {lim, cs}, {i[1:0], 1'b0})
    end
    $display("test control done");
    ge = 1;
    wr(0, 8'h88, 8'h80);
    rd(8'h88, 8'h80);
    `CHK("on", {on, ss, code, mv}, {2'b11, 5'h00, 13'hFD2})
    repeat (9980) @(negedge clk);
    `CHK("soft start", ss, 1'b1)
    rd(8'h89, 8'hFD);
    repeat (30) @(negedge clk);
    `CHK("soft start end", ss, 1'b0)
    ge = 0;
    repeat (5) @(negedge clk);
    `CHK("global off", on, 1'b0)
    rd(8'h88, 8'h80);
    $display("test enable done");
    ce = 0;
    wr(1, 8'h89, 8'h00);
    ce = 1;
    rd(8'h89, 8'hDD);
    `CHK("frozen", {lim, cs}, 3'h6)
    $display("test clock enable done");
    wr(0, 8'h88, 8'h6A);
    rd(8'h88, 8'h6A);
    `CHK("code", {on, code, mv}, {1'b0, 5'h0A, 13'h11C6})
    rst = 1;
    repeat (3) @(negedge clk);
    rst = 0;
    rd(8'h88, 8'h13);
    rd(8'h89, 8'h0E);
    $display("test reset done");
    test_done;
  end
endmodule
bind bstreg_regs bstreg_asserts chk (.clk(clk), .rst(rst), .ce(ce), .i2c_wr(i2c_wr),
  .uc_wr(uc_wr), .global_enable(global_enable), .i2c_addr(i2c_addr),
  .i2c_wdata(i2c_wdata), .i2c_rdata_ff(i2c_rdata_ff), .uc_wdata(uc_wdata),
  .uc_addr(uc_addr), .regulator_on_ff(regulator_on_ff),
  .clock_1mhz_sel_ff(clock_1mhz_sel_ff), .soft_start_ff(soft_start_ff),
  .output_voltage_code_ff(output_voltage_code_ff), .target_mv_ff(target_mv_ff),
  .peak_current_limit_select_ff(peak_current_limit_select_ff));
